// File: design/cic_defs.vh
// constants for the core interrupt control block
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH

// ------------------------------------------------------------
// register indices (8-bit registers on a plain port)
// ------------------------------------------------------------
`define CIC_ADDR_W        5
`define CIC_A_CTRL        5'h00
`define CIC_A_CORE_EN     5'h01
`define CIC_A_CORE_FLAG   5'h02
`define CIC_A_PEN_BASE    5'h08
`define CIC_A_PFLAG_BASE  5'h10
`define CIC_A_IRQ_STAT    5'h18
`define CIC_A_IRQ_MASK    5'h19
`define CIC_A_SHADOW_W    5'h1a
`define CIC_A_SHADOW_ST   5'h1b
`define CIC_A_SHADOW_BSR  5'h1c
`define CIC_A_SHADOW_PCH  5'h1d

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define CIC_CTRL_GIE      7
`define CIC_CTRL_PERIPH_IRQ_ENABLE     6
`define CIC_CTRL_EDGE     0
`define CIC_CTRL_RST      8'h01
`define CIC_CORE_EXT_BIT  0
`define CIC_STATUS_KEEP   8'he7
`define CIC_VECTOR        15'h0004
`define CIC_PERIPH_REGS   7

// ------------------------------------------------------------
// sticky event bits of the block's own status register
// ------------------------------------------------------------
`define CIC_EV_ENTRY      0
`define CIC_EV_RETURN     1
`define CIC_EV_EXTEDGE    2

`endif

// File: design/cic_flag_reg.v
// one sticky flag register: hardware set wins over software clear
`timescale 1ns/1ps
module cic_flag_reg #(
    parameter W = 8
) (
    input  wire         clock_i,
    input  wire         rstn_i,
    input  wire [W-1:0] set_i,
    input  wire         wr_i,
    input  wire [W-1:0] wdata_i,
    output reg  [W-1:0] flag_o
);
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_o <= {W{1'b0}};
        end else begin
            // bits set this cycle survive a write of zero
            flag_o <= (wr_i ? wdata_i : flag_o) | set_i;
        end
    end
endmodule // cic_flag_reg

// File: design/cic_shadow.v
// shadow context store: captured on entry, written by software
`timescale 1ns/1ps
`include "cic_defs.vh"
module cic_shadow (
    input  wire        clock_i,
    input  wire        rstn_i,
    input  wire        save_i,
    input  wire [7:0]  w_i,
    input  wire [7:0]  st_i,
    input  wire [7:0]  bsr_i,
    input  wire [7:0]  pch_i,
    input  wire [15:0] fsr0_i,
    input  wire [15:0] fsr1_i,
    input  wire        wr_i,
    input  wire [1:0]  wsel_i,
    input  wire [7:0]  wdata_i,
    output reg  [7:0]  w_o,
    output reg  [7:0]  st_o,
    output reg  [7:0]  bsr_o,
    output reg  [7:0]  pch_o,
    output reg  [15:0] fsr0_o,
    output reg  [15:0] fsr1_o
);
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            w_o    <= 8'h00;
            st_o   <= 8'h00;
            bsr_o  <= 8'h00;
            pch_o  <= 8'h00;
            fsr0_o <= 16'h0000;
            fsr1_o <= 16'h0000;
        end else if (save_i) begin
            w_o    <= w_i;
            // timeout and power-down flags are not shadowed
            st_o   <= (st_i & `CIC_STATUS_KEEP) | (st_o & ~`CIC_STATUS_KEEP);
            bsr_o  <= bsr_i;
            pch_o  <= pch_i;
            fsr0_o <= fsr0_i;
            fsr1_o <= fsr1_i;
        end else if (wr_i) begin
            case (wsel_i)
                2'h0: begin
                    w_o <= wdata_i;
                end
                2'h1: begin
                    st_o <= wdata_i;
                end
                2'h2: begin
                    bsr_o <= wdata_i;
                end
                default: begin
                    pch_o <= wdata_i;
                end
            endcase
        end
    end
endmodule // cic_shadow

// File: design/cic_core.v
// core interrupt control: gating, entry sequence, context shadow
// How it works
// - any reset leaves all interrupts disabled
// - vector needs global and own enable
// - peripheral sources also need group enable
// - flags set regardless of any enable
// - taking: flush prefetch, clear global enable
// - taking pushes program counter on stack
// - taking copies core registers to shadows
// - then load program counter with 0004h
// - in handler events flag but never vector
// - return pops, restores context, sets global enable
// - held interrupts taken once global enable returns
// - uncleared flag retakes interrupt after return
// - core-enabled sources need no group enable
// - shadow working, status-minus-two-flags, bank, pointers, latch
// - external pin edge per polarity select
`timescale 1ns/1ps
`include "cic_defs.vh"
module cic_core #(
    parameter NP = `CIC_PERIPH_REGS
) (
    input  wire                   clock_i,
    input  wire                   rstn_i,
    input  wire [`CIC_ADDR_W-1:0] addr_i,
    input  wire [7:0]             wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output reg  [7:0]             rdata_o,
    input  wire [NP*8-1:0]        periph_event_i,
    input  wire [7:0]             core_event_i,
    input  wire                   external_request_pin_i,
    input  wire [14:0]            pc_i,
    input  wire [7:0]             working_reg_i,
    input  wire [7:0]             status_i,
    input  wire [7:0]             bank_select_i,
    input  wire [7:0]             pc_high_latch_i,
    input  wire [15:0]            fsr0_i,
    input  wire [15:0]            fsr1_i,
    input  wire                   return_from_irq_i,
    output reg                    flush_o,
    output reg                    push_o,
    output reg  [14:0]            push_pc_o,
    output reg                    pop_o,
    output reg                    load_pc_o,
    output reg  [14:0]            load_pc_addr_o,
    output reg                    restore_o,
    output reg  [7:0]             working_reg_o,
    output reg  [7:0]             status_o,
    output reg  [7:0]             bank_select_o,
    output reg  [7:0]             pc_high_latch_o,
    output reg  [15:0]            fsr0_o,
    output reg  [15:0]            fsr1_o,
    output reg                    irq_o
);
    // ------------------------------------------------------------
    // entry sequence states
    // ------------------------------------------------------------
    localparam [1:0] S_RUN  = 2'd0;
    localparam [1:0] S_SAVE = 2'd1;
    localparam [1:0] S_VEC  = 2'd2;

    reg  [7:0]      ctrl_q;
    reg  [7:0]      core_en_q;
    reg  [NP*8-1:0] pen_q;
    reg  [7:0]      mask_q;
    reg  [7:0]      stat_q;
    reg  [1:0]      state_q;
    reg             pin_q;
    reg             pin_ok_q;
    reg  [7:0]      ctrl_d;
    wire [7:0]      core_flag;
    wire [NP*8-1:0] pflag;
    wire [7:0]      core_set;
    wire [7:0]      ev_set;
    wire [7:0]      sh_w;
    wire [7:0]      sh_st;
    wire [7:0]      sh_bsr;
    wire [7:0]      sh_pch;
    wire [15:0]     sh_f0;
    wire [15:0]     sh_f1;
    wire            global_irq_enable;
    wire            ext_edge;
    wire            core_req;
    wire            periph_req;
    wire            take;
    wire            sh_wr;

    assign global_irq_enable = ctrl_q[`CIC_CTRL_GIE];
    // pin is synchronous; edge chosen by polarity select
    // no edge in the first cycle after reset: pin_q has not yet seen the pin
    assign ext_edge = pin_ok_q & (ctrl_q[`CIC_CTRL_EDGE] ? (external_request_pin_i & ~pin_q)
                                                         : (~external_request_pin_i & pin_q));
    assign core_set = core_event_i | {7'h00, ext_edge};

    // ------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------
    cic_flag_reg #(.W(8)) u_core_flag (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .set_i   (core_set),
        .wr_i    (wr_i && addr_i == `CIC_A_CORE_FLAG),
        .wdata_i (wdata_i),
        .flag_o  (core_flag)
    );

    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_per
            cic_flag_reg #(.W(8)) u_pflag (
                .clock_i (clock_i),
                .rstn_i  (rstn_i),
                .set_i   (periph_event_i[g*8 +: 8]),
                .wr_i    (wr_i && addr_i == `CIC_A_PFLAG_BASE + g),
                .wdata_i (wdata_i),
                .flag_o  (pflag[g*8 +: 8])
            );
            always @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    pen_q[g*8 +: 8] <= 8'h00;
                end else if (wr_i && addr_i == `CIC_A_PEN_BASE + g) begin
                    pen_q[g*8 +: 8] <= wdata_i;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // request forming
    // ------------------------------------------------------------
    // flags persist, so a held or uncleared one is taken again
    assign core_req   = |(core_flag & core_en_q);
    assign periph_req = ctrl_q[`CIC_CTRL_PERIPH_IRQ_ENABLE] & (|(pflag & pen_q));
    // global enable gates everything, so the handler never nests
    assign take = global_irq_enable && state_q == S_RUN && (core_req || periph_req);

    // ------------------------------------------------------------
    // control register and entry sequence
    // ------------------------------------------------------------
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_i && addr_i == `CIC_A_CTRL) begin
            ctrl_d = wdata_i & 8'hc1;
        end
        if (return_from_irq_i) begin
            ctrl_d[`CIC_CTRL_GIE] = 1'b1;
        end
        if (take) begin
            ctrl_d[`CIC_CTRL_GIE] = 1'b0;
        end
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q         <= `CIC_CTRL_RST;
            core_en_q      <= 8'h00;
            mask_q         <= 8'h00;
            state_q        <= S_RUN;
            pin_q          <= 1'b0;
            pin_ok_q       <= 1'b0;
            flush_o        <= 1'b0;
            push_o         <= 1'b0;
            push_pc_o      <= 15'h0000;
            pop_o          <= 1'b0;
            load_pc_o      <= 1'b0;
            load_pc_addr_o <= 15'h0000;
            restore_o      <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            pin_q     <= external_request_pin_i;
            pin_ok_q  <= 1'b1;
            flush_o   <= take;
            push_o    <= take;
            load_pc_o <= 1'b0;
            if (take) begin
                push_pc_o <= pc_i;
            end
            pop_o     <= return_from_irq_i;
            restore_o <= return_from_irq_i;
            if (wr_i && addr_i == `CIC_A_CORE_EN) begin
                core_en_q <= wdata_i;
            end
            if (wr_i && addr_i == `CIC_A_IRQ_MASK) begin
                mask_q <= wdata_i;
            end
            case (state_q)
                S_RUN: begin
                    if (take) begin
                        state_q <= S_SAVE;
                    end
                end
                S_SAVE: begin
                    state_q <= S_VEC;
                end
                S_VEC: begin
                    load_pc_o      <= 1'b1;
                    load_pc_addr_o <= `CIC_VECTOR;
                    state_q        <= S_RUN;
                end
                default: begin
                    state_q <= S_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // shadow context
    // ------------------------------------------------------------
    assign sh_wr = wr_i && addr_i >= `CIC_A_SHADOW_W && addr_i <= `CIC_A_SHADOW_PCH;

    cic_shadow u_shadow (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .save_i  (take),
        .w_i     (working_reg_i),
        .st_i    (status_i),
        .bsr_i   (bank_select_i),
        .pch_i   (pc_high_latch_i),
        .fsr0_i  (fsr0_i),
        .fsr1_i  (fsr1_i),
        .wr_i    (sh_wr),
        .wsel_i  (addr_i[1:0] - 2'h2),
        .wdata_i (wdata_i),
        .w_o     (sh_w),
        .st_o    (sh_st),
        .bsr_o   (sh_bsr),
        .pch_o   (sh_pch),
        .fsr0_o  (sh_f0),
        .fsr1_o  (sh_f1)
    );

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            working_reg_o   <= 8'h00;
            status_o        <= 8'h00;
            bank_select_o   <= 8'h00;
            pc_high_latch_o <= 8'h00;
            fsr0_o          <= 16'h0000;
            fsr1_o          <= 16'h0000;
        end else if (return_from_irq_i) begin
            working_reg_o   <= sh_w;
            status_o        <= sh_st;
            bank_select_o   <= sh_bsr;
            pc_high_latch_o <= sh_pch;
            fsr0_o          <= sh_f0;
            fsr1_o          <= sh_f1;
        end
    end

    // ------------------------------------------------------------
    // block status, mask and interrupt line
    // ------------------------------------------------------------
    assign ev_set = {5'h00, ext_edge, return_from_irq_i, take};

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_q <= 8'h00;
            irq_o  <= 1'b0;
        end else begin
            // write-one-to-clear; a new event in the same cycle wins
            if (wr_i && addr_i == `CIC_A_IRQ_STAT) begin
                stat_q <= (stat_q & ~wdata_i) | ev_set;
            end else begin
                stat_q <= stat_q | ev_set;
            end
            irq_o <= |(stat_q & mask_q);
        end
    end

    // ------------------------------------------------------------
    // read port: data stand in the cycle after the strobe
    // ------------------------------------------------------------
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (addr_i >= `CIC_A_PEN_BASE && addr_i < `CIC_A_PEN_BASE + NP) begin
                rdata_o <= pen_q[(addr_i - `CIC_A_PEN_BASE)*8 +: 8];
            end else if (addr_i >= `CIC_A_PFLAG_BASE && addr_i < `CIC_A_PFLAG_BASE + NP) begin
                rdata_o <= pflag[(addr_i - `CIC_A_PFLAG_BASE)*8 +: 8];
            end else begin
                case (addr_i)
                    `CIC_A_CTRL:       rdata_o <= ctrl_q;
                    `CIC_A_CORE_EN:    rdata_o <= core_en_q;
                    `CIC_A_CORE_FLAG:  rdata_o <= core_flag;
                    `CIC_A_IRQ_STAT:   rdata_o <= stat_q;
                    `CIC_A_IRQ_MASK:   rdata_o <= mask_q;
                    `CIC_A_SHADOW_W:   rdata_o <= sh_w;
                    `CIC_A_SHADOW_ST:  rdata_o <= sh_st;
                    `CIC_A_SHADOW_BSR: rdata_o <= sh_bsr;
                    `CIC_A_SHADOW_PCH: rdata_o <= sh_pch;
                    default:           rdata_o <= 8'h00;
                endcase
            end
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule // cic_core

// File: tb/cic_core_model.sv
// behavioural processor core: program counter, return stack, live context
`timescale 1ns/1ps
module cic_core_model (
    input  wire        clock_i,
    input  wire        rstn_i,
    input  wire        push_i,
    input  wire [14:0] push_pc_i,
    input  wire        pop_i,
    input  wire        load_i,
    input  wire [14:0] load_addr_i,
    output wire [14:0] pc_o,
    output wire [7:0]  w_o,
    output wire [7:0]  st_o,
    output wire [7:0]  bsr_o,
    output wire [7:0]  pch_o,
    output wire [15:0] fsr0_o,
    output wire [15:0] fsr1_o
);
    reg [14:0] stack_q [0:15];
    reg [14:0] pc_q;
    reg [3:0]  sp_q;
    // context tracks the pc, so each entry captures values not seen before
    assign pc_o   = pc_q;
    assign w_o    = pc_q[7:0];
    assign st_o   = ~pc_q[7:0];
    assign bsr_o  = pc_q[7:0] ^ 8'h3c;
    assign pch_o  = {1'b0, pc_q[14:8]};
    assign fsr0_o = {pc_q, 1'b1};
    assign fsr1_o = {1'b0, ~pc_q};
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_q <= 15'h0100;
            sp_q <= 4'h0;
        end else if (push_i) begin
            stack_q[sp_q] <= push_pc_i;
            sp_q <= sp_q + 4'h1;
            pc_q <= pc_q + 15'h0001;
        end else if (pop_i) begin
            pc_q <= stack_q[sp_q - 4'h1];
            sp_q <= sp_q - 4'h1;
        end else if (load_i) begin
            pc_q <= load_addr_i;
        end else begin
            pc_q <= pc_q + 15'h0001;
        end
    end
endmodule // cic_core_model

// File: tb/cic_core_checker.sv
// assertions on the ports of the core interrupt control block
`timescale 1ns/1ps
module cic_core_checker (
    input wire        clock_i,
    input wire        rstn_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [7:0]  rdata_o,
    input wire [14:0] pc_i,
    input wire [7:0]  working_reg_i,
    input wire [7:0]  status_i,
    input wire        return_from_irq_i,
    input wire        flush_o,
    input wire        push_o,
    input wire [14:0] push_pc_o,
    input wire        pop_o,
    input wire        load_pc_o,
    input wire [14:0] load_pc_addr_o,
    input wire        restore_o,
    input wire [7:0]  working_reg_o,
    input wire [7:0]  status_o
);
    reg       in_isr_q;
    reg       armed_q;
    reg [7:0] w_cap_q;
    reg [7:0] st_cap_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_isr_q <= 1'b0;
            armed_q  <= 1'b0;
            w_cap_q  <= 8'h00;
            st_cap_q <= 8'h00;
        end else begin
            if (wr_i) armed_q <= 1'b1;
            if (flush_o) begin
                in_isr_q <= 1'b1;
                w_cap_q  <= $past(working_reg_i);
                st_cap_q <= $past(status_i);
            end else if (pop_o) begin
                in_isr_q <= 1'b0;
            end
        end
    end
    push_with_flush_a: assert property (flush_o == push_o)
        else $error("push and flush not together");
    vector_delay_a: assert property (flush_o |-> ##2 load_pc_o)
        else $error("vector load not two cycles after flush");
    vector_addr_a: assert property (load_pc_o |-> load_pc_addr_o == 15'h0004 && $past(flush_o, 2))
        else $error("vector load wrong");
    push_pc_a: assert property (push_o |-> push_pc_o == $past(pc_i))
        else $error("pushed pc wrong");
    return_pop_a: assert property (return_from_irq_i && in_isr_q |=> pop_o && restore_o)
        else $error("return gave no pop");
    restore_ctx_a: assert property (restore_o |-> working_reg_o == w_cap_q
        && (status_o & 8'he7) == (st_cap_q & 8'he7))
        else $error("restored context wrong");
    isr_no_take_a: assert property (in_isr_q |-> !flush_o)
        else $error("take inside handler");
    reset_quiet_a: assert property (!armed_q |-> !flush_o)
        else $error("take before any enable");
    take_spacing_a: assert property (flush_o |=> !flush_o ##1 !flush_o)
        else $error("entry sequence overlapped");
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    take_c: cover property (flush_o);
    return_c: cover property (pop_o);
    retake_c: cover property (pop_o ##1 flush_o);
endmodule // cic_core_checker

bind cic_core cic_core_checker chk (.clock_i(clock_i), .rstn_i(rstn_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pc_i(pc_i), .working_reg_i(working_reg_i),
    .status_i(status_i), .return_from_irq_i(return_from_irq_i), .flush_o(flush_o),
    .push_o(push_o), .push_pc_o(push_pc_o), .pop_o(pop_o), .load_pc_o(load_pc_o),
    .load_pc_addr_o(load_pc_addr_o), .restore_o(restore_o),
    .working_reg_o(working_reg_o), .status_o(status_o));

// File: tb/core_interrupt_control_tb_top.sv
// testbench for the core interrupt control block
`timescale 1ns/1ps
module core_interrupt_control_tb_top;
    reg         clock_i = 1'b0;
    reg         rstn_i  = 1'b0;
    reg  [4:0]  addr_i  = 5'h00;
    reg  [7:0]  wdata_i = 8'h00;
    reg         wr_i    = 1'b0;
    reg         rd_i    = 1'b0;
    reg  [55:0] pev_i   = 56'h0;
    reg  [7:0]  cev_i   = 8'h00;
    reg         pin_i   = 1'b0;
    reg         ret_i   = 1'b0;
    wire [7:0]  rdata_o, w, st, bank_select, pch;
    wire [14:0] pc, ppc, lda;
    wire [15:0] f0, f1;
    wire        flush, push, pop, ld, irq_o;
    wire [7:0]  bso, pho;
    wire [15:0] fo0, fo1;
    reg  [55:0] ctx_d1, ctx_cap;
    integer     n_errors = 0;
    integer     compares = 0;
    integer     n_take   = 0;
    cic_core dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .periph_event_i(pev_i),
        .core_event_i(cev_i), .external_request_pin_i(pin_i), .pc_i(pc),
        .working_reg_i(w), .status_i(st), .bank_select_i(bank_select), .pc_high_latch_i(pch),
        .fsr0_i(f0), .fsr1_i(f1), .return_from_irq_i(ret_i), .flush_o(flush),
        .push_o(push), .push_pc_o(ppc), .pop_o(pop), .load_pc_o(ld),
        .load_pc_addr_o(lda), .restore_o(), .working_reg_o(), .status_o(),
        .bank_select_o(bso), .pc_high_latch_o(pho), .fsr0_o(fo0), .fsr1_o(fo1), .irq_o(irq_o));
    cic_core_model core (.clock_i(clock_i), .rstn_i(rstn_i), .push_i(push),
        .push_pc_i(ppc), .pop_i(pop), .load_i(ld), .load_addr_i(lda), .pc_o(pc),
        .w_o(w), .st_o(st), .bsr_o(bank_select), .pch_o(pch), .fsr0_o(f0), .fsr1_o(f1));
    initial forever #5 clock_i = ~clock_i;
    // live context one edge back is what the block saw at the take edge
    always @(posedge clock_i) begin
        ctx_d1 <= {w, bank_select, pch, f0, f1};
        if (flush === 1'b1) begin
            n_take  <= n_take + 1;
            ctx_cap <= ctx_d1;
        end
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task results;
        begin
            $display("compares %0d errors %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        begin
            @(posedge clock_i);
            addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
            @(posedge clock_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [4:0] a, input [7:0] exp);
        begin
            @(posedge clock_i);
            addr_i <= a; rd_i <= 1'b1;
            @(posedge clock_i);
            rd_i <= 1'b0;
            #1 chk(rdata_o, exp);
        end
    endtask
    task ev(input [55:0] p, input [7:0] c, input r);
        begin
            @(posedge clock_i);
            pev_i <= p; cev_i <= c; ret_i <= r;
            @(posedge clock_i);
            pev_i <= 56'h0; cev_i <= 8'h00; ret_i <= 1'b0;
            repeat (4) @(posedge clock_i);
        end
    endtask
    task wait_take(input integer n);
        integer k;
        begin
            for (k = 0; k < 12 && n_take != n; k = k + 1) @(posedge clock_i);
            chk(n_take, n);
            if (n_take != n) results;
            repeat (3) @(posedge clock_i);
        end
    endtask
    initial begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd(5'h00, 8'h01);
        rd(5'h01, 8'h00);
        rd(5'h0a, 8'h00);
        rd(5'h07, 8'h00);
        $display("test reset done");
        @(posedge clock_i) pin_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(5'h02, 8'h01);
        wr(5'h02, 8'h00);
        wr(5'h00, 8'h00);
        @(posedge clock_i) pin_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rd(5'h02, 8'h01);
        wr(5'h02, 8'h00);
        @(posedge clock_i) pin_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(5'h02, 8'h00);
        $display("test edge select done");
        ev(56'h80000, 8'h00, 1'b0);
        rd(5'h12, 8'h08);
        wr(5'h0a, 8'h08);
        wr(5'h00, 8'h80);
        repeat (6) @(posedge clock_i);
        chk(n_take, 0);
        wr(5'h00, 8'hc0);
        wait_take(1);
        rd(5'h00, 8'h40);
        wr(5'h01, 8'h02);
        ev(56'h0, 8'h02, 1'b0);
        chk(n_take, 1);
        rd(5'h02, 8'h02);
        wr(5'h12, 8'h00);
        ev(56'h0, 8'h00, 1'b1);
        chk(n_take, 2);
        wr(5'h02, 8'h00);
        ev(56'h0, 8'h00, 1'b1);
        rd(5'h00, 8'hc0);
        chk({bso, pho}, ctx_cap[47:32]);
        chk(fo0, ctx_cap[31:16]);
        chk(fo1, ctx_cap[15:0]);
        $display("test entry and return done");
        wr(5'h00, 8'h00);
        ev(56'h0, 8'h02, 1'b0);
        chk(n_take, 2);
        wr(5'h00, 8'h80);
        wait_take(3);
        rd(5'h1a, ctx_cap[55:48]);
        wr(5'h1c, 8'h5a);
        wr(5'h02, 8'h00);
        ev(56'h0, 8'h00, 1'b1);
        chk({bso, pho}, {8'h5a, ctx_cap[39:32]});
        ev(56'h80000, 8'h00, 1'b0);
        @(posedge clock_i);
        addr_i <= 5'h12; wdata_i <= 8'h00; wr_i <= 1'b1; pev_i <= 56'h200000;
        @(posedge clock_i);
        wr_i <= 1'b0; pev_i <= 56'h0;
        rd(5'h12, 8'h20);
        chk(n_take, 3);
        $display("test flag write done");
        rd(5'h18, 8'h07);
        chk(irq_o, 1'b0);
        wr(5'h19, 8'h01);
        repeat (3) @(posedge clock_i);
        chk(irq_o, 1'b1);
        wr(5'h18, 8'h01);
        repeat (3) @(posedge clock_i);
        chk(irq_o, 1'b0);
        rd(5'h18, 8'h06);
        wr(5'h07, 8'hff);
        rd(5'h07, 8'h00);
        $display("test status done");
        @(posedge clock_i) rstn_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd(5'h00, 8'h01);
        rd(5'h12, 8'h00);
        rd(5'h19, 8'h00);
        rd(5'h02, 8'h00);
        chk(n_take, 3);
        $display("test second reset done");
        results;
    end
endmodule // core_interrupt_control_tb_top
